/* File: logic/entry_fifo.sv */
// Purpose: Small shift FIFO between qualifier core and trace memory.
// Assumes: Synchronous active-high reset; one clock.
// Notes:   Head entry, valid and ready are all flip-flops.
`timescale 1ns/1ps

module entry_fifo #(
	parameter int WIDTH = 57,           // Entry width
	parameter int DEPTH = 2             // Number of entries
) (
	input  wire logic             clk_i,      // System clock
	input  wire logic             rst_i,      // Sync reset, high
	input  wire logic             in_valid_i, // Entry offered
	input  wire logic [WIDTH-1:0] in_data_i,  // Entry offered
	output logic                  in_ready_o, // Room for an entry
	output logic                  out_valid_o,// Head entry valid
	output logic [WIDTH-1:0]      out_data_o, // Head entry
	input  wire logic             out_ready_i // Receiver takes head
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;   // Slot 0 is the head
		logic [DEPTH-1:0]            vld;   // Slot occupied
		logic                        rdy;   // Registered ready
	} fifo_state_t;

	fifo_state_t s;                      // Current state
	fifo_state_t n;                      // Next state

	// Pop shifts toward head, push fills first free slot
	always_comb begin
		logic placed;
		placed = 1'b0;
		n = s;
		if (s.vld[0] && out_ready_i) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				n.mem[i] = s.mem[i+1];
				n.vld[i] = s.vld[i+1];
			end
			n.vld[DEPTH-1] = 1'b0;
		end
		if (in_valid_i && s.rdy) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (!placed && !n.vld[i]) begin
					n.mem[i] = in_data_i;
					n.vld[i] = 1'b1;
					placed   = 1'b1;
				end
			end
		end
		n.rdy = !n.vld[DEPTH-1];
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s     <= '0;
			s.rdy <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign in_ready_o  = s.rdy;
	assign out_valid_o = s.vld[0];
	assign out_data_o  = s.mem[0];

endmodule

/* File: logic/trace_store.sv */
// Purpose: Storage, prestore and count qualification of sampled states.
// Assumes: Sampled states arrive as a valid/ready stream; trigger comes
//          from the sequencer; registers over classic Wishbone.
// Notes:   A stored state costs two clocks; any CTRL write re-arms.
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module trace_store
	import trace_store_pkg::*;
#(
	parameter int BUF_DEPTH = 2          // Output buffer entries
) (
	input  wire logic              clk_i,          // 20 MHz clock
	input  wire logic              rst_i,          // Sync reset, high
	input  wire logic              wb_cyc_i,       // Bus cycle
	input  wire logic              wb_stb_i,       // Bus strobe
	input  wire logic              wb_we_i,        // Write enable
	input  wire logic [7:0]        wb_adr_i,       // Byte address
	input  wire logic [3:0]        wb_sel_i,       // Byte enables
	input  wire logic [31:0]       wb_dat_i,       // Write data
	output logic [31:0]            wb_dat_o,       // Read data
	output logic                   wb_ack_o,       // Acknowledge
	input  wire logic              state_valid_i,  // Sample present
	input  wire logic [`ADDR_W-1:0] state_addr_i,  // Sampled address
	input  wire logic [`DATA_W-1:0] state_data_i,  // Sampled data
	input  wire logic [`STAT_W-1:0] state_stat_i,  // Sampled status
	input  wire logic              state_trig_i,   // Sample is trigger
	input  wire logic              arm_i,          // Arm term
	output logic                   state_ready_o,  // Sample taken
	output logic                   out_valid_o,    // Entry valid
	input  wire logic              out_ready_i,    // Memory takes entry
	output logic [`ADDR_W-1:0]     out_addr_o,     // Entry address
	output logic [`DATA_W-1:0]     out_data_o,     // Entry data
	output logic [`STAT_W-1:0]     out_stat_o,     // Entry status
	output logic [`TAG_W-1:0]      out_tag_o,      // Count or marker
	output logic                   out_trig_o      // Entry is trigger
);

	localparam int EW = $bits(entry_t);   // Entry width

	core_state_t s;                        // Current state
	core_state_t n;                        // Next state
	logic        acc;                      // Sample accepted
	logic        hit_store;                // Storage qualifier
	logic        hit_pre;                  // Prestore qualifier
	logic        hit_count;                // Count qualifier
	logic        is_norm;                  // Normal store
	logic        pre_take;                 // Goes to prestore
	logic        push_v;                   // Entry to buffer
	logic        push_pre;                 // Entry is prestore
	entry_t      push_e;                   // Entry offered
	logic        buf_rdy;                  // Buffer has room
	logic        buf_vld;                  // Buffer head valid
	entry_t      buf_head;                 // Buffer head entry
	logic [5:0]  set1;                     // a..d, r, not r
	logic [4:0]  set2;                     // e..h, arm
	logic [`NPAT-1:0] pat;                 // Pattern matches
	logic        in_rng;                   // Address in range
	logic        wr;                       // Write takes effect
	logic [1:0]  cmode;                    // Count mode

	// Byte-lane merge of a write
	function automatic logic [31:0] be_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// One set: uniform OR, or uniform NOR, of chosen members
	function automatic logic set_eval(input logic [5:0] mem,
		input logic [5:0] msk, input logic nor_op);
		logic any;
		any = |(mem & msk);
		return nor_op ? !any : any;
	endfunction

	// Qualifier: set1 combined by AND or OR with set2
	function automatic logic qual_eval(input logic [`QUAL_W-1:0] q,
		input logic [5:0] m1, input logic [4:0] m2);
		logic a;
		logic b;
		a = set_eval(m1, q[`QUAL_S1_LO +: 6], q[`QUAL_S1_NOR]);
		b = set_eval({1'b0, m2}, {1'b0, q[`QUAL_S2_LO +: 5]},
			q[`QUAL_S2_NOR]);
		return q[`QUAL_OR] ? (a | b) : (a & b);
	endfunction

	// Pattern and range matches on address, data and status
	always_comb begin
		for (int i = 0; i < `NPAT; i++) begin
			pat[i] = ((({state_data_i, state_addr_i} ^ s.pval[i])
				& s.pmsk[i]) == 32'h0000_0000) &&
				(((state_stat_i ^ s.pstat[i][7:0])
				& s.pstat[i][15:8]) == 8'h00);
		end
		in_rng = (state_addr_i >= s.rlo) && (state_addr_i <= s.rhi);
		set1 = {!in_rng, in_rng, pat[3:0]};
		set2 = {arm_i, pat[7:4]};
	end

	assign cmode     = s.ctrl[`CTRL_CMODE_LO +: 2];
	assign hit_store = qual_eval(s.qual[0], set1, set2);
	assign hit_pre   = qual_eval(s.qual[1], set1, set2);
	assign hit_count = qual_eval(s.qual[2], set1, set2);
	assign acc       = s.rdy && state_valid_i;
	assign is_norm   = state_trig_i || hit_store;
	assign pre_take  = !is_norm && hit_pre &&
		s.ctrl[`CTRL_PRE_EN];
	assign wr        = wb_cyc_i && wb_stb_i && wb_we_i && s.ack;

	// Buffer feed: prestore entries first, then the held store
	always_comb begin
		push_v   = (s.st == S_DRAIN);
		push_pre = (s.pcnt != 2'h0);
		push_e   = push_pre ? s.pend[0] : s.held;
		if (push_pre) begin
			push_e.tag = (cmode == `CMODE_OFF) ? `TAG_W'(0)
				: `TAG_MARK;
		end
	end

	// Next state: bus slave, qualifier core, drain sequencer
	always_comb begin
		entry_t smp;
		smp = '{trig: state_trig_i, tag: s.cnt, stat: state_stat_i,
			data: state_data_i, addr: state_addr_i};
		n = s;
		// Bus answer one clock after the request, dropped after
		n.ack  = wb_cyc_i && wb_stb_i && !s.ack;
		n.rdat = 32'h0000_0000;
		if (wb_adr_i >= `REG_PAT_BASE && wb_adr_i < `REG_PAT_END) begin
			case (wb_adr_i[3:2])
				2'h0:    n.rdat = s.pval[{wb_adr_i[7], wb_adr_i[5:4]}];
				2'h1:    n.rdat = s.pmsk[{wb_adr_i[7], wb_adr_i[5:4]}];
				2'h2:    n.rdat = {16'h0000,
					s.pstat[{wb_adr_i[7], wb_adr_i[5:4]}]};
				default: n.rdat = 32'h0000_0000;
			endcase
		end else begin
			case (wb_adr_i)
				`REG_CTRL:       n.rdat = {28'h0, s.ctrl};
				`REG_STATUS:     n.rdat = {13'h0, (s.st == S_DRAIN),
					s.pcnt, s.nstored};
				`REG_QUAL_STORE: n.rdat = {18'h0, s.qual[0]};
				`REG_QUAL_PRE:   n.rdat = {18'h0, s.qual[1]};
				`REG_QUAL_COUNT: n.rdat = {18'h0, s.qual[2]};
				`REG_RANGE_LO:   n.rdat = {16'h0, s.rlo};
				`REG_RANGE_HI:   n.rdat = {16'h0, s.rhi};
				default:         n.rdat = 32'h0000_0000;
			endcase
		end

		// Time tag counts clocks since the last normal store
		if (s.ctrl[`CTRL_RUN] && cmode == `CMODE_TIME &&
			s.cnt != `TAG_MAX) begin
			n.cnt = s.cnt + `TAG_W'(1);
		end

		// Accepted sample
		if (acc) begin
			if (is_norm) begin
				n.held = smp;
				if (cmode == `CMODE_OFF) begin
					n.held.tag = `TAG_W'(0);
				end
				n.cnt = `TAG_W'(0);
				n.st  = S_DRAIN;
			end else begin
				if (cmode == `CMODE_STATE && hit_count &&
					s.cnt != `TAG_MAX) begin
					n.cnt = s.cnt + `TAG_W'(1);
				end
				if (pre_take) begin
					// Newest two kept, oldest dropped
					if (s.pcnt == 2'h2) begin
						n.pend[0] = s.pend[1];
						n.pend[1] = smp;
					end else begin
						n.pend[s.pcnt[0]] = smp;
						n.pcnt = s.pcnt + 2'h1;
					end
				end
			end
		end

		// Drain one entry per clock while the buffer has room
		case (s.st)
			S_IDLE: begin
			end
			S_DRAIN: begin
				if (buf_rdy) begin
					if (push_pre) begin
						n.pend[0] = s.pend[1];
						n.pcnt    = s.pcnt - 2'h1;
					end else begin
						n.st = S_IDLE;
					end
					n.nstored = s.nstored + 16'h0001;
				end
			end
			default: n.st = S_IDLE;
		endcase

		// Register writes
		if (wr) begin
			if (wb_adr_i >= `REG_PAT_BASE && wb_adr_i < `REG_PAT_END) begin
				case (wb_adr_i[3:2])
					2'h0: n.pval[{wb_adr_i[7], wb_adr_i[5:4]}] = be_merge(
						s.pval[{wb_adr_i[7], wb_adr_i[5:4]}], wb_dat_i,
						wb_sel_i);
					2'h1: n.pmsk[{wb_adr_i[7], wb_adr_i[5:4]}] = be_merge(
						s.pmsk[{wb_adr_i[7], wb_adr_i[5:4]}], wb_dat_i,
						wb_sel_i);
					2'h2: n.pstat[{wb_adr_i[7], wb_adr_i[5:4]}] = 16'(be_merge(
						{16'h0, s.pstat[{wb_adr_i[7], wb_adr_i[5:4]}]},
						wb_dat_i, wb_sel_i));
					default: begin
					end
				endcase
			end else begin
				case (wb_adr_i)
					`REG_CTRL: begin
						// Re-arm: drop pending work and counts
						n.ctrl    = `CTRL_W'(be_merge({28'h0, s.ctrl},
							wb_dat_i, wb_sel_i));
						n.pcnt    = 2'h0;
						n.cnt     = `TAG_W'(0);
						n.nstored = 16'h0000;
						n.st      = S_IDLE;
					end
					`REG_QUAL_STORE: n.qual[0] = `QUAL_W'(be_merge(
						{18'h0, s.qual[0]}, wb_dat_i, wb_sel_i));
					`REG_QUAL_PRE:   n.qual[1] = `QUAL_W'(be_merge(
						{18'h0, s.qual[1]}, wb_dat_i, wb_sel_i));
					`REG_QUAL_COUNT: n.qual[2] = `QUAL_W'(be_merge(
						{18'h0, s.qual[2]}, wb_dat_i, wb_sel_i));
					`REG_RANGE_LO:   n.rlo = `ADDR_W'(be_merge(
						{16'h0, s.rlo}, wb_dat_i, wb_sel_i));
					`REG_RANGE_HI:   n.rhi = `ADDR_W'(be_merge(
						{16'h0, s.rhi}, wb_dat_i, wb_sel_i));
					default: begin
					end
				endcase
			end
		end
		n.rdy = (n.st == S_IDLE) && n.ctrl[`CTRL_RUN];
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s      <= '0;
			s.st   <= S_IDLE;
			s.ctrl <= `CTRL_RST;
		end else begin
			s <= n;
		end
	end

	// Output buffer, stalls the drain when full
	entry_fifo #(
		.WIDTH (EW),
		.DEPTH (BUF_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (push_v),
		.in_data_i   (push_e),
		.in_ready_o  (buf_rdy),
		.out_valid_o (buf_vld),
		.out_data_o  (buf_head),
		.out_ready_i (out_ready_i)
	);

	assign wb_ack_o      = s.ack;
	assign wb_dat_o      = s.rdat;
	assign state_ready_o = s.rdy;
	assign out_valid_o   = buf_vld;
	assign out_addr_o    = buf_head.addr;
	assign out_data_o    = buf_head.data;
	assign out_stat_o    = buf_head.stat;
	assign out_tag_o     = buf_head.tag;
	assign out_trig_o    = buf_head.trig;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_trig_store;
		acc && state_trig_i && !wr |=> s.st == S_DRAIN && s.held.trig;
	endproperty
	a_trig_store: assert property (p_trig_store)
		else $error("trigger state not held for storing");

	property p_pend_max;
		s.pcnt <= 2'h2;
	endproperty
	a_pend_max: assert property (p_pend_max)
		else $error("more than two prestore entries pending");

	property p_pre_first;
		push_v && buf_rdy && push_pre && !wr
			|=> s.st == S_DRAIN && s.pcnt == $past(s.pcnt) - 2'h1;
	endproperty
	a_pre_first: assert property (p_pre_first)
		else $error("store entry pushed ahead of prestore");

	property p_marker;
		push_v && push_pre && cmode != `CMODE_OFF |-> push_e.tag == `TAG_MARK;
	endproperty
	a_marker: assert property (p_marker)
		else $error("prestore entry lacks marker");

	property p_pre_keeps_ref;
		acc && pre_take && cmode == `CMODE_STATE && !hit_count && !wr
			|=> s.cnt == $past(s.cnt);
	endproperty
	a_pre_keeps_ref: assert property (p_pre_keeps_ref)
		else $error("prestore moved the count reference");

	property p_count_off;
		acc && pre_take && cmode == `CMODE_OFF && !wr |=> s.pcnt != 2'h0;
	endproperty
	a_count_off: assert property (p_count_off)
		else $error("prestore lost with counting off");

	property p_both_normal;
		acc && hit_store && hit_pre && !wr
			|=> s.st == S_DRAIN && s.pcnt == $past(s.pcnt);
	endproperty
	a_both_normal: assert property (p_both_normal)
		else $error("dual match treated as prestore");

	property p_discard;
		acc && !is_norm && !pre_take && s.st == S_IDLE && !wr
			|=> s.st == S_IDLE && $stable(s.pcnt);
	endproperty
	a_discard: assert property (p_discard)
		else $error("unqualified state was kept");

	property p_drain_clears;
		s.st == S_DRAIN ##1 s.st == S_IDLE |-> s.pcnt == 2'h0;
	endproperty
	a_drain_clears: assert property (p_drain_clears)
		else $error("prestore buffer not cleared by store");

	c_trig: cover property (acc && state_trig_i);
	c_two_pre: cover property (s.pcnt == 2'h2 ##[1:50] s.st == S_DRAIN);
	c_stall: cover property (push_v && !buf_rdy);
	c_drop: cover property (acc && pre_take && s.pcnt == 2'h2);

endmodule

/* File: logic/trace_store_pkg.sv */
// Purpose: Types of the trace storage qualifier block.
// Assumes: Constants come from trace_store_regs.svh.
// Notes:   Core state is one packed struct registered in one process.
`include "trace_store_regs.svh"

package trace_store_pkg;

	// Drain sequencer states, one-hot
	typedef enum logic [1:0] {
		S_IDLE  = 2'b01,
		S_DRAIN = 2'b10
	} fsm_t;

	// One trace memory entry
	typedef struct packed {
		logic                 trig;
		logic [`TAG_W-1:0]    tag;
		logic [`STAT_W-1:0]   stat;
		logic [`DATA_W-1:0]   data;
		logic [`ADDR_W-1:0]   addr;
	} entry_t;

	// Complete state of the qualifier core
	typedef struct packed {
		logic                        ack;
		logic [31:0]                 rdat;
		logic [`CTRL_W-1:0]          ctrl;
		logic [2:0][`QUAL_W-1:0]     qual;
		logic [`ADDR_W-1:0]          rlo;
		logic [`ADDR_W-1:0]          rhi;
		logic [`NPAT-1:0][31:0]      pval;
		logic [`NPAT-1:0][31:0]      pmsk;
		logic [`NPAT-1:0][15:0]      pstat;
		fsm_t                        st;
		logic                        rdy;
		logic [1:0]                  pcnt;
		entry_t [1:0]                pend;
		entry_t                      held;
		logic [`TAG_W-1:0]           cnt;
		logic [15:0]                 nstored;
	} core_state_t;

endpackage

/* File: logic/trace_store_regs.svh */
// Purpose: Offsets, field positions, widths and reset values of the
//          trace storage qualifier block.
// Assumes: 32-bit classic Wishbone, byte addresses, one word per register.
// Notes:   Definitions only; shared by the package and the modules.
`ifndef TRACE_STORE_REGS_SVH
`define TRACE_STORE_REGS_SVH

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_QUAL_STORE  8'h08
`define REG_QUAL_PRE    8'h0c
`define REG_QUAL_COUNT  8'h10
`define REG_RANGE_LO    8'h14
`define REG_RANGE_HI    8'h18
`define REG_PAT_BASE    8'h40
`define REG_PAT_END     8'hc0

// Control fields
`define CTRL_RUN        0
`define CTRL_PRE_EN     1
`define CTRL_CMODE_LO   2
`define CTRL_W          4
`define CMODE_OFF       2'h0
`define CMODE_TIME      2'h1
`define CMODE_STATE     2'h2

// Qualifier word fields
`define QUAL_S1_LO      0
`define QUAL_S1_NOR     6
`define QUAL_S2_LO      7
`define QUAL_S2_NOR     12
`define QUAL_OR         13
`define QUAL_W          14

// Sample and entry widths
`define ADDR_W          16
`define DATA_W          16
`define STAT_W          8
`define TAG_W           16
`define NPAT            8

// Tag marker for prestore entries, largest count below it
`define TAG_MARK        16'hffff
`define TAG_MAX         16'hfffe

// Reset values
`define CTRL_RST        4'h0
`define QUAL_RST        14'h0000
`define RANGE_RST       16'h0000

`endif

/* File: test/state_source.sv */
// Purpose: Target bus model offering sampled states one at a time.
// Assumes: Ready is registered and sampled at the rising edge.
// Notes:   Released lines carry the inverse of the last value.
`timescale 1ns/1ps

module state_source (
	input  wire logic        clk_i,   // Clock
	input  wire logic        ready_i, // Sample taken
	output logic             valid_o, // Sample present
	output logic [15:0]      addr_o,  // Bus address
	output logic [15:0]      data_o,  // Bus data
	output logic [7:0]       stat_o,  // Bus status
	output logic             trig_o,  // Trigger state
	output logic             arm_o    // Arm term
);
	// Idle bus at time zero
	initial begin
		{valid_o, addr_o, data_o, stat_o, trig_o, arm_o} = '0;
	end

	// Offer one state, hold it until the accepting edge
	task automatic send(input logic [15:0] a, input logic [15:0] d,
		input logic t, input logic m);
		@(posedge clk_i);
		valid_o <= 1'b1;
		{addr_o, data_o, stat_o, trig_o, arm_o} <= {a, d, 8'h00, t, m};
		do @(posedge clk_i); while (ready_i !== 1'b1);
		valid_o <= 1'b0;
		{addr_o, data_o, stat_o, trig_o, arm_o} <= ~{a, d, 8'h00, t, m};
	endtask
endmodule

/* File: test/trace_store_bench.sv */
// Purpose: Self-checking bench of the trace storage qualifier.
// Assumes: Pattern a is address 0100, b is data 6100, c address 0300.
// Notes:   Trace memory side stalls one cycle in three.
`timescale 1ns/1ps
`include "trace_store_regs.svh"

module trace_store_bench;
	import trace_store_pkg::*;
	logic        clk_i, rst_i, cyc, stb, we, ack, ov, ordy, otrig;
	logic        sv, strig, sarm, srdy;
	logic [7:0]  adr, ss, os;
	logic [3:0]  sel;
	logic [31:0] wdat, rdat, q;
	logic [15:0] sa, sd, oa, od, otag;
	logic [56:0] got_q[$];    // Entries: {trig, tag, stat, data, addr}
	int          n_errors, checks, tick;
	logic [13:0] e_q[0:5] = '{14'h2001, 14'h2041, 14'h2041,
		14'h0801, 14'h0801, 14'h2011};
	logic [15:0] e_a[0:5] = '{16'h0100, 16'h0100, 16'h0777,
		16'h0100, 16'h0100, 16'h0777};
	logic        e_m[0:5] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
	logic        e_s[0:5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};

	trace_store dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.state_valid_i(sv), .state_addr_i(sa), .state_data_i(sd),
		.state_stat_i(ss), .state_trig_i(strig), .arm_i(sarm),
		.state_ready_o(srdy), .out_valid_o(ov), .out_ready_i(ordy),
		.out_addr_o(oa), .out_data_o(od), .out_stat_o(os),
		.out_tag_o(otag), .out_trig_o(otrig));
	state_source src_u (.clk_i(clk_i), .ready_i(srdy), .valid_o(sv),
		.addr_o(sa), .data_o(sd), .stat_o(ss), .trig_o(strig),
		.arm_o(sarm));

	// Clock, 50 ns period
	always #25 clk_i = ~clk_i;

	// Trace memory: collects entries, stalls now and then
	always @(posedge clk_i) begin
		if (ov && ordy) begin
			got_q.push_back({otrig, otag, os, od, oa});
		end
		tick <= tick + 1;
		ordy <= (tick % 3) != 2;
	end

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Classic single Wishbone cycle, waits for ack
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		{cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		q = rdat;
		{cyc, stb} <= 2'b00;
	endtask

	// Next entry must match, waits a bounded time
	task automatic expect_entry(input logic t, input logic [15:0] g,
		input logic [15:0] d, input logic [15:0] a);
		int n;
		n = 0;
		while (got_q.size() == 0 && n < 60) begin
			@(posedge clk_i);
			n++;
		end
		if (got_q.size() == 0) begin
			check(64'h0, {t, g, 8'h00, d, a});
		end else begin
			check(got_q.pop_front(), {t, g, 8'h00, d, a});
		end
	endtask

	// Nothing further may reach trace memory
	task automatic expect_none();
		repeat (12) @(posedge clk_i);
		check(got_q.size(), 0);
	endtask

	// Qualifiers first, control last since it re-arms
	task automatic setup(input logic [3:0] c, input logic [13:0] s,
		input logic [13:0] p, input logic [13:0] n);
		wb(1'b1, `REG_QUAL_STORE, {18'h0, s});
		wb(1'b1, `REG_QUAL_PRE, {18'h0, p});
		wb(1'b1, `REG_QUAL_COUNT, {18'h0, n});
		wb(1'b1, `REG_CTRL, {28'h0, c});
	endtask

	// Reset values, unmapped place, readback
	task automatic t_regs();
		wb(1'b0, `REG_CTRL, 32'h0);
		check(q, 32'h0);
		wb(1'b0, 8'h30, 32'h0);
		check(q, 32'h0);
		wb(1'b1, 8'h30, 32'hffffffff);
		wb(1'b1, `REG_QUAL_STORE, 32'hffff2001);
		wb(1'b0, `REG_QUAL_STORE, 32'h0);
		check(q, 32'h00002001);
		$display("test regs done");
	endtask

	// Prestore window, order, markers and state count
	task automatic t_prestore();
		setup(4'hb, 14'h2001, 14'h2002, 14'h2004);
		src_u.send(16'h0010, 16'h6100, 1'b0, 1'b0);
		src_u.send(16'h0300, 16'h0000, 1'b0, 1'b0);
		src_u.send(16'h0020, 16'h6100, 1'b0, 1'b0);
		src_u.send(16'h0030, 16'h6100, 1'b0, 1'b0);
		src_u.send(16'h0300, 16'h0000, 1'b0, 1'b0);
		src_u.send(16'h0777, 16'h0000, 1'b0, 1'b0);
		src_u.send(16'h0100, 16'h0000, 1'b0, 1'b0);
		expect_entry(1'b0, `TAG_MARK, 16'h6100, 16'h0020);
		expect_entry(1'b0, `TAG_MARK, 16'h6100, 16'h0030);
		expect_entry(1'b0, 16'h0002, 16'h0000, 16'h0100);
		src_u.send(16'h0100, 16'h6100, 1'b0, 1'b0);
		expect_entry(1'b0, 16'h0000, 16'h6100, 16'h0100);
		expect_none();
		$display("test prestore done");
	endtask

	// Trigger kept though unqualified
	task automatic t_trigger();
		src_u.send(16'h0555, 16'h0000, 1'b1, 1'b0);
		expect_entry(1'b1, 16'h0000, 16'h0000, 16'h0555);
		src_u.send(16'h0556, 16'h0000, 1'b0, 1'b0);
		expect_none();
		wb(1'b0, `REG_STATUS, 32'h0);
		check(q, 32'h00000005);
		$display("test trigger done");
	endtask

	// Count off: prestore still kept, no marker
	task automatic t_countoff();
		setup(4'h3, 14'h2001, 14'h2002, 14'h2004);
		src_u.send(16'h0020, 16'h6100, 1'b0, 1'b0);
		src_u.send(16'h0100, 16'h0000, 1'b0, 1'b0);
		expect_entry(1'b0, 16'h0000, 16'h6100, 16'h0020);
		expect_entry(1'b0, 16'h0000, 16'h0000, 16'h0100);
		$display("test countoff done");
	endtask

	// Time tags run from the last store; prestore leaves them be
	task automatic t_time();
		setup(4'h7, 14'h2001, 14'h2002, 14'h2004);
		src_u.send(16'h0020, 16'h6100, 1'b0, 1'b0);
		src_u.send(16'h0100, 16'h0000, 1'b0, 1'b0);
		src_u.send(16'h0030, 16'h6100, 1'b0, 1'b0);
		src_u.send(16'h0100, 16'h0000, 1'b0, 1'b0);
		expect_entry(1'b0, `TAG_MARK, 16'h6100, 16'h0020);
		expect_entry(1'b0, 16'h0003, 16'h0000, 16'h0100);
		expect_entry(1'b0, `TAG_MARK, 16'h6100, 16'h0030);
		expect_entry(1'b0, 16'h0004, 16'h0000, 16'h0100);
		$display("test time done");
	endtask

	// Set operators, arm term and range term
	task automatic t_expr();
		for (int i = 0; i < 6; i++) begin
			setup(4'h1, e_q[i], 14'h0, 14'h0);
			src_u.send(e_a[i], 16'h0000, 1'b0, e_m[i]);
			if (e_s[i]) begin
				expect_entry(1'b0, 16'h0000, 16'h0000, e_a[i]);
			end else begin
				expect_none();
			end
		end
		$display("test expr done");
	endtask

	task automatic final_report();
		$display("checks=%0d errors=%0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		{clk_i, rst_i, cyc, stb, we, adr, sel, wdat} = '0;
		rst_i = 1'b1;
		{n_errors, checks} = '0;
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		wb(1'b1, `REG_PAT_BASE + 8'h00, 32'h00000100);
		wb(1'b1, `REG_PAT_BASE + 8'h04, 32'h0000ffff);
		wb(1'b1, `REG_PAT_BASE + 8'h10, 32'h61000000);
		wb(1'b1, `REG_PAT_BASE + 8'h14, 32'hffff0000);
		wb(1'b1, `REG_PAT_BASE + 8'h20, 32'h00000300);
		wb(1'b1, `REG_PAT_BASE + 8'h24, 32'h0000ffff);
		wb(1'b1, `REG_RANGE_LO, 32'h00000700);
		wb(1'b1, `REG_RANGE_HI, 32'h000007ff);
		t_prestore();
		t_trigger();
		t_countoff();
		t_expr();
		t_time();
		final_report();
	end

	// Watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		final_report();
	end
endmodule
